// File: src/roc_conditioner.sv
`timescale 1ns/100ps
// Contract
// - each of seven inputs has its own inversion setting, off after reset
// - every relay output change is held at least the hold time, 0..300 s
// - with latching on, a picked-up relay stays on after inputs drop
// - the single relay has one acknowledge input to release the latch
// - acknowledge acts only while latching is enabled
module roc_conditioner #(
  parameter int TICK_CYCLES = roc_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [roc_pkg::NUM_SIG-1:0] sigIn,
  input wire logic ackIn,
  output logic relayOut,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic awHave;
    logic [31:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic latchEn;
    logic [roc_pkg::NUM_SIG-1:0] invMask;
    logic [roc_pkg::TIME_W-1:0] holdSet;
    logic [roc_pkg::TIME_W-1:0] offSet;
    logic offRun;
    logic [roc_pkg::TIME_W-1:0] offCnt;
    logic latched;
    logic relay;
    logic [roc_pkg::TIME_W-1:0] holdCnt;
  } roc_state_t;

  roc_state_t s_q;
  roc_state_t s_d;
  logic cmd;
  logic want;
  logic desired;
  logic relayChg;
  logic holdTick;
  logic offTick;
  logic holdDone;
  logic [31:0] ctrlWord;
  logic [31:0] holdWord;
  logic [31:0] offWord;
  logic [31:0] statWord;
  logic [31:0] ctrlNew;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // merge write data into a word by byte strobes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction

  // clamp a time setting to 300.00 s
  function automatic logic [roc_pkg::TIME_W-1:0] clamp_time(input logic [31:0] w);
    logic [roc_pkg::TIME_W-1:0] res;
    if (w > 32'(roc_pkg::TIME_MAX_CS))
      res = roc_pkg::TIME_MAX;
    else
      res = w[roc_pkg::TIME_W-1:0];
    return res;
  endfunction

  // ----------------------------------------
  // step timers
  // ----------------------------------------
  // hold timer restarts on every relay change
  roc_tick #(.CYCLES(TICK_CYCLES)) u_hold_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clr(relayChg),
    .tick(holdTick)
  );

  // off-delay timer restarts while the command is present
  roc_tick #(.CYCLES(TICK_CYCLES)) u_off_tick (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clr(cmd),
    .tick(offTick)
  );

  // ----------------------------------------
  // register views
  // ----------------------------------------
  // readable words built from state
  always_comb
  begin
    ctrlWord = '0;
    ctrlWord[roc_pkg::CTRL_LATCH_BIT] = s_q.latchEn;
    ctrlWord[roc_pkg::CTRL_INV_LSB +: roc_pkg::NUM_SIG] = s_q.invMask;
    holdWord = 32'(s_q.holdSet);
    offWord = 32'(s_q.offSet);
    statWord = '0;
    statWord[roc_pkg::STAT_RELAY_BIT] = s_q.relay;
    statWord[roc_pkg::STAT_LATCHED_BIT] = s_q.latched;
    statWord[roc_pkg::STAT_OFFRUN_BIT] = s_q.offRun;
    statWord[roc_pkg::STAT_HOLDBUSY_BIT] = !holdDone;
    statWord[roc_pkg::STAT_CMD_BIT] = cmd;
    statWord[roc_pkg::STAT_SIG_LSB +: roc_pkg::NUM_SIG] = sigIn;
    ctrlNew = merge_bytes(ctrlWord, s_q.wData, s_q.wStrb); // control word after a pending write
  end

  // ----------------------------------------
  // relay conditioning
  // ----------------------------------------
  // inverted inputs ORed into one command
  assign cmd = |(sigIn ^ s_q.invMask);
  assign want = cmd || s_q.offRun;
  assign desired = want || s_q.latched;
  assign holdDone = s_q.holdCnt >= s_q.holdSet;
  assign relayChg = (desired != s_q.relay) && holdDone;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    s_d = s_q;
    // off delay: stretch the command after it drops
    if (cmd)
    begin
      s_d.offRun = 1'b1;
      s_d.offCnt = '0;
    end
    else if (s_q.offRun)
    begin
      if (s_q.offCnt >= s_q.offSet)
        s_d.offRun = 1'b0;
      else if (offTick)
        s_d.offCnt = s_q.offCnt + roc_pkg::TIME_W'(1);
    end
    // latch: set wins over acknowledge, cleared when disabled
    s_d.latched = s_q.latchEn && (want || (s_q.latched && !ackIn));
    // relay with minimum hold
    if (relayChg)
    begin
      s_d.relay = desired;
      s_d.holdCnt = '0;
    end
    else if (holdTick && s_q.holdCnt != roc_pkg::TIME_MAX)
      s_d.holdCnt = s_q.holdCnt + roc_pkg::TIME_W'(1);
    // write address and data, taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.awHave = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.wHave = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    // perform write once both halves are here
    if (s_q.awHave && s_q.wHave)
    begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = roc_pkg::RESP_OKAY;
      unique case (s_q.awAddr)
        roc_pkg::ADDR_CTRL:
        begin
          s_d.latchEn = ctrlNew[roc_pkg::CTRL_LATCH_BIT];
          s_d.invMask = ctrlNew[roc_pkg::CTRL_INV_LSB +: roc_pkg::NUM_SIG];
        end
        roc_pkg::ADDR_HOLD:
        begin
          s_d.holdSet = clamp_time(merge_bytes(holdWord, s_q.wData, s_q.wStrb));
        end
        roc_pkg::ADDR_OFFDLY:
        begin
          s_d.offSet = clamp_time(merge_bytes(offWord, s_q.wData, s_q.wStrb));
        end
        roc_pkg::ADDR_STATUS:
        begin
          s_d.bResp = roc_pkg::RESP_OKAY;
        end
        default:
        begin
          s_d.bResp = roc_pkg::RESP_SLVERR;
        end
      endcase
    end
    // write response
    if (s_q.bValid && s_axi_bready)
      s_d.bValid = 1'b0;
    // read channel
    if (s_q.rValid && s_axi_rready)
      s_d.rValid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rValid = 1'b1;
      s_d.rResp = roc_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        roc_pkg::ADDR_CTRL: s_d.rData = ctrlWord;
        roc_pkg::ADDR_HOLD: s_d.rData = holdWord;
        roc_pkg::ADDR_OFFDLY: s_d.rData = offWord;
        roc_pkg::ADDR_STATUS: s_d.rData = statWord;
        default:
        begin
          s_d.rData = '0;
          s_d.rResp = roc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_q <= '0;
      s_q.invMask <= roc_pkg::INV_RST;
      s_q.latchEn <= roc_pkg::LATCH_RST;
      s_q.holdSet <= roc_pkg::HOLD_RST;
      s_q.offSet <= roc_pkg::OFFDLY_RST;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign relayOut = s_q.relay;
  assign s_axi_awready = !s_q.awHave && !s_q.bValid;
  assign s_axi_wready = !s_q.wHave && !s_q.bValid;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_arready = !s_q.rValid;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  inv_default_a: assert property (@(posedge ref_clk)
    !$past(nrst) && nrst |-> s_q.invMask == roc_pkg::INV_RST)
    else $error("inversion not off after reset");

  inv_command_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (|(sigIn ^ s_q.invMask)) |=> s_q.offRun)
    else $error("inverted input did not raise the command");

  hold_min_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(s_q.relay) |-> $past(s_q.holdCnt) >= $past(s_q.holdSet))
    else $error("relay changed before hold time");

  hold_zero_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.holdSet == 15'h0000 && desired != s_q.relay |=> s_q.relay == $past(desired))
    else $error("relay did not follow with zero hold");

  latch_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.latchEn && s_q.latched && !ackIn ##1 s_q.latchEn |-> s_q.latched)
    else $error("latched state lost without acknowledge");

  ack_release_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.latchEn && ackIn && !want |=> !s_q.latched)
    else $error("acknowledge did not release the latch");

  ack_ignored_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.latchEn |=> !s_q.latched)
    else $error("latch held while latching disabled");

  off_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.offRun && !cmd && s_q.offCnt < s_q.offSet |=> s_q.offRun)
    else $error("off delay ended early");
endmodule

// File: include/roc_pkg.sv
package roc_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_HOLD = 32'h0000_0004;
  localparam logic [31:0] ADDR_OFFDLY = 32'h0000_0008;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_LATCH_BIT = 0;
  localparam int CTRL_INV_LSB = 8;
  localparam int STAT_RELAY_BIT = 0;
  localparam int STAT_LATCHED_BIT = 1;
  localparam int STAT_OFFRUN_BIT = 2;
  localparam int STAT_HOLDBUSY_BIT = 3;
  localparam int STAT_CMD_BIT = 4;
  localparam int STAT_SIG_LSB = 8;

  // ----------------------------------------
  // sizes and values after reset
  // ----------------------------------------
  localparam int NUM_SIG = 7;
  localparam int TIME_W = 15;
  localparam logic [NUM_SIG-1:0] INV_RST = 7'h00;
  localparam logic LATCH_RST = 1'b0;
  localparam logic [TIME_W-1:0] HOLD_RST = 15'h0000;
  localparam logic [TIME_W-1:0] OFFDLY_RST = 15'h0000;

  // ----------------------------------------
  // timing: settings count 10 ms steps, 0.00 .. 300.00 s
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_NS = 10_000_000;
  localparam int TIME_MAX_CS = 30000;
  localparam int TICK_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam logic [TIME_W-1:0] TIME_MAX = TIME_W'(TIME_MAX_CS);
  localparam int TICK_W = 20;

  // ----------------------------------------
  // bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: src/roc_tick.sv
`timescale 1ns/100ps
// step pulse generator, restarted by clr so a step always starts fresh
module roc_tick #(
  parameter int CYCLES = roc_pkg::TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clr,
  output logic tick
);
  logic [roc_pkg::TICK_W-1:0] cnt_q;
  logic [roc_pkg::TICK_W-1:0] cnt_d;

  // count one step, wrap and pulse
  always_comb
  begin
    tick = (cnt_q == roc_pkg::TICK_W'(CYCLES - 1)) && !clr;
    if (clr || tick)
      cnt_d = '0;
    else
      cnt_d = cnt_q + roc_pkg::TICK_W'(1);
  end

  // step counter
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// File: dv/roc_load.sv
`timescale 1ns/100ps
// ----------------------------------------
// relay load: times how long each contact state stands
// ----------------------------------------
module roc_load (
  input wire logic ref_clk,
  input wire logic relayOut,
  output logic [15:0] lastHigh,
  output logic [15:0] lastLow
);
  logic prevQ = 1'b0;
  logic [15:0] runQ = 16'h0000;
  initial
  begin
    lastHigh = 16'h0000;
    lastLow = 16'h0000;
  end
  // length of the current state, stored when it ends
  always @(posedge ref_clk)
  begin
    prevQ <= relayOut;
    runQ <= (relayOut != prevQ) ? 16'h0001 : runQ + 16'h0001;
    if (relayOut != prevQ && prevQ)
      lastHigh <= runQ;
    if (relayOut != prevQ && !prevQ)
      lastLow <= runQ;
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic ref_clk, nrst, ackIn, awvalid, wvalid, arvalid;
  logic [6:0] sigIn;
  logic [31:0] awaddr, wdata, araddr;
  wire logic relayOut, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [15:0] lastHigh, lastLow;
  int n_mismatch = 0;
  int samples_checked = 0;

  roc_conditioner #(.TICK_CYCLES(4)) DUT (.ref_clk(ref_clk), .nrst(nrst), .sigIn(sigIn), .ackIn(ackIn),
    .relayOut(relayOut), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
  roc_load load (.ref_clk(ref_clk), .relayOut(relayOut), .lastHigh(lastHigh), .lastLow(lastLow));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    chk(bresp, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    chk(rdata, d);
    chk(rresp, r);
  endtask

  // bounded wait for the relay to reach a level
  task automatic wait_rel(input logic v);
    for (int k = 0; k < 60 && relayOut !== v; k++) @(negedge ref_clk);
    chk(relayOut, v);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(roc_pkg::ADDR_CTRL, 32'h0, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_HOLD, 32'h0, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_OFFDLY, 32'h0, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_STATUS, 32'h0, roc_pkg::RESP_OKAY);
    wr(roc_pkg::ADDR_STATUS, 32'hffff_ffff, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_STATUS, 32'h0, roc_pkg::RESP_OKAY);
    rd(32'h10, 32'h0, roc_pkg::RESP_SLVERR);
    wr(32'h10, 32'h1, roc_pkg::RESP_SLVERR);
    chk(relayOut, 1'b0);
  endtask

  task automatic t_invert;
    logic [6:0] base;
    for (int m = 0; m < 2; m++)
    begin
      base = m ? 7'h7f : 7'h00;
      for (int i = 0; i < 7; i++)
      begin
        wr(roc_pkg::ADDR_CTRL, {17'h0, base, 8'h00}, roc_pkg::RESP_OKAY);
        @(posedge ref_clk);
        sigIn <= base;
        wait_rel(1'b0);
        @(posedge ref_clk);
        sigIn <= base ^ (7'h01 << i);
        wait_rel(1'b1);
        @(posedge ref_clk);
        sigIn <= base;
        wait_rel(1'b0);
      end
    end
    rd(roc_pkg::ADDR_CTRL, 32'h0000_7f00, roc_pkg::RESP_OKAY);
    wr(roc_pkg::ADDR_CTRL, 32'h0, roc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    sigIn <= 7'h00;
    wait_rel(1'b0);
  endtask

  task automatic t_hold;
    wr(roc_pkg::ADDR_HOLD, 32'd40000, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_HOLD, roc_pkg::TIME_MAX_CS, roc_pkg::RESP_OKAY);
    wr(roc_pkg::ADDR_HOLD, 32'd3, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_HOLD, 32'd3, roc_pkg::RESP_OKAY);
    // let the hold of the previous change run out first
    repeat (16) @(posedge ref_clk);
    sigIn <= 7'h01;
    @(posedge ref_clk);
    sigIn <= 7'h00;
    wait_rel(1'b1);
    wait_rel(1'b0);
    @(posedge ref_clk);
    sigIn <= 7'h01;
    wait_rel(1'b1);
    @(negedge ref_clk);
    chk(lastHigh >= 16'd12, 1'b1);
    chk(lastLow >= 16'd12, 1'b1);
    @(posedge ref_clk);
    sigIn <= 7'h00;
    wait_rel(1'b0);
    wr(roc_pkg::ADDR_HOLD, 32'h0, roc_pkg::RESP_OKAY);
  endtask

  task automatic t_offdly;
    wr(roc_pkg::ADDR_OFFDLY, 32'd2, roc_pkg::RESP_OKAY);
    rd(roc_pkg::ADDR_OFFDLY, 32'd2, roc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    sigIn <= 7'h40;
    wait_rel(1'b1);
    @(posedge ref_clk);
    sigIn <= 7'h00;
    repeat (8) @(negedge ref_clk);
    chk(relayOut, 1'b1);
    wait_rel(1'b0);
    wr(roc_pkg::ADDR_OFFDLY, 32'h0, roc_pkg::RESP_OKAY);
  endtask

  task automatic t_latch;
    wr(roc_pkg::ADDR_CTRL, 32'h1, roc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    sigIn <= 7'h02;
    @(posedge ref_clk);
    sigIn <= 7'h00;
    wait_rel(1'b1);
    repeat (20) @(negedge ref_clk);
    chk(relayOut, 1'b1);
    rd(roc_pkg::ADDR_STATUS, 32'h0000_0003, roc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    ackIn <= 1'b1;
    @(posedge ref_clk);
    ackIn <= 1'b0;
    wait_rel(1'b0);
    wr(roc_pkg::ADDR_CTRL, 32'h0, roc_pkg::RESP_OKAY);
    @(posedge ref_clk);
    ackIn <= 1'b1;
    sigIn <= 7'h04;
    wait_rel(1'b1);
    repeat (10) @(negedge ref_clk);
    chk(relayOut, 1'b1);
    @(posedge ref_clk);
    sigIn <= 7'h00;
    ackIn <= 1'b0;
    wait_rel(1'b0);
  endtask

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial
  begin
    #100us;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    nrst = 1'b0;
    sigIn = 7'h00;
    ackIn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_invert();
    t_hold();
    t_offdly();
    t_latch();
    wrap_up();
  end
endmodule
